// ### core/qdu_core.sv
`timescale 1ns/10ps
`default_nettype none
module qdu_core
	import qdu_pkg::*;
(
	input wire logic core_clk_i, // Core clock, 50 MHz
	input wire logic rstn_i, // Power-on reset, active low
	input wire logic sclk_i, // Serial clock pin
	input wire logic sdin_i, // Serial data pin
	input wire logic sync_n_i, // Frame select pin, active low
	input wire logic load_strobe_n_i, // Load strobe pin, active low
	input wire logic hw_reset_n_i, // Hardware reset pin, active low
	input wire logic reset_level_select_i, // 0 zero scale, 1 midscale
	output logic [DAC_BITS-1:0] dac_a_o, // Channel A DAC register
	output logic [DAC_BITS-1:0] dac_b_o, // Channel B DAC register
	output logic [DAC_BITS-1:0] dac_c_o, // Channel C DAC register
	output logic [DAC_BITS-1:0] dac_d_o, // Channel D DAC register
	output logic ref_enable_o, // Internal reference on
	output logic [NUM_CH-1:0] load_mask_o, // Load mask register
	output logic ready_o // Initialization complete
);
	// ==========================================
	// Pin synchronisers
	// ==========================================
	logic [5:0] pins_s;
	// Select pin starts at zero scale so power-up never flashes midscale
	localparam logic [5:0] SYNC_RESET = 6'h3e;
	qdu_sync #(.WIDTH(6), .RESET_VAL(SYNC_RESET)) u_sync (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.async_i({sclk_i, sdin_i, sync_n_i, load_strobe_n_i, hw_reset_n_i,
			reset_level_select_i}),
		.reset_val_i(SYNC_RESET),
		.sync_o(pins_s)
	);
	logic sclk_s;
	logic sdin_s;
	logic sync_n_s;
	logic strobe_n_s;
	logic hw_rst_n_s;
	logic rsel_s;
	assign sclk_s = pins_s[5];
	assign sdin_s = pins_s[4];
	assign sync_n_s = pins_s[3];
	assign strobe_n_s = pins_s[2];
	assign hw_rst_n_s = pins_s[1];
	assign rsel_s = pins_s[0];

	// ==========================================
	// Frame receiver
	// ==========================================
	logic [FRAME_BITS-1:0] word;
	logic word_valid;
	qdu_shift_rx u_rx (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.sclk_s_i(sclk_s),
		.sdin_s_i(sdin_s),
		.sync_n_s_i(sync_n_s),
		.word_o(word),
		.word_valid_o(word_valid)
	);

	// ==========================================
	// Initialization state
	// ==========================================
	typedef enum logic [1:0] {
		QDU_POR,
		QDU_HOLD,
		QDU_RUN
	} qdu_state_e;
	qdu_state_e state;
	logic [POR_CNT_BITS-1:0] por_cnt;
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= QDU_POR;
			por_cnt <= '0;
		end else begin
			case (state)
				QDU_POR: begin
					if (!hw_rst_n_s) begin
						por_cnt <= '0;
					end else if (por_cnt == POR_CNT_BITS'(POR_CYCLES - 1)) begin
						state <= QDU_RUN;
					end else begin
						por_cnt <= por_cnt + POR_CNT_BITS'(1);
					end
				end
				QDU_HOLD: begin
					if (hw_rst_n_s)
						state <= QDU_RUN;
				end
				QDU_RUN: begin
					if (!hw_rst_n_s)
						state <= QDU_HOLD;
				end
				default: state <= QDU_POR;
			endcase
		end
	end
	logic running;
	assign running = (state == QDU_RUN) && hw_rst_n_s;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			ready_o <= 1'b0;
		else
			ready_o <= (state == QDU_RUN);
	end

	// ==========================================
	// Strobe edge and mask handling
	// ==========================================
	logic strobe_n_d;
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			strobe_n_d <= 1'b1;
		else if (state != QDU_RUN)
			strobe_n_d <= 1'b1;
		else
			strobe_n_d <= strobe_n_s;
	end
	logic strobe_fall;
	assign strobe_fall = running && strobe_n_d && !strobe_n_s;

	logic [NUM_CH-1:0] mask;
	assign load_mask_o = mask;

	// Per-channel effective strobe: masked channel sees high
	function automatic logic [NUM_CH-1:0] eff_low(input logic [NUM_CH-1:0] m, input logic pin_low);
		eff_low = pin_low ? ~m : '0;
	endfunction

	// ==========================================
	// Command decode
	// ==========================================
	logic [3:0] cmd;
	logic [NUM_CH-1:0] addr;
	logic [DAC_BITS-1:0] data;
	assign cmd = word[CMD_HI:CMD_LO];
	assign addr = word[ADDR_HI:ADDR_LO];
	assign data = word[DATA_HI:DATA_LO];
	logic cmd_ok;
	assign cmd_ok = word_valid && running;

	logic soft_reset;
	assign soft_reset = cmd_ok && (cmd == CMD_SOFT_RESET);

	logic [DAC_BITS-1:0] reset_code;
	assign reset_code = rsel_s ? MID_CODE : ZERO_CODE;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			mask <= MASK_RESET;
		else if (soft_reset)
			mask <= MASK_RESET;
		else if (cmd_ok && cmd == CMD_LOAD_MASK)
			mask <= word[NUM_CH-1:0];
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			ref_enable_o <= !REF_DISABLE_RESET;
		else if (soft_reset)
			ref_enable_o <= !REF_DISABLE_RESET;
		else if (cmd_ok && cmd == CMD_REF_SETUP)
			ref_enable_o <= !word[REF_BIT];
	end

	// ==========================================
	// Input and DAC registers
	// ==========================================
	logic [DAC_BITS-1:0] in_reg [NUM_CH];
	logic [DAC_BITS-1:0] dac_reg [NUM_CH];
	logic clear_now;
	logic [NUM_CH-1:0] strobe_low_ch;
	logic pin_low_run;
	assign clear_now = (state == QDU_POR) || !hw_rst_n_s || soft_reset;
	// Strobe held low: mask disregarded, pin acts on all channels
	assign pin_low_run = !strobe_n_s;
	assign strobe_low_ch = eff_low(mask, pin_low_run);

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NUM_CH; i++) begin
				in_reg[i] <= ZERO_CODE;
				dac_reg[i] <= ZERO_CODE;
			end
		end else if (clear_now) begin
			for (int i = 0; i < NUM_CH; i++) begin
				in_reg[i] <= reset_code;
				dac_reg[i] <= reset_code;
			end
		end else if (running) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (strobe_fall && !mask[i])
					dac_reg[i] <= in_reg[i];
				if (cmd_ok && addr[i]) begin
					case (cmd)
						CMD_WRITE_INPUT: begin
							in_reg[i] <= data;
							if (strobe_low_ch[i] || pin_low_run)
								dac_reg[i] <= data;
						end
						CMD_UPDATE_DAC: dac_reg[i] <= in_reg[i];
						CMD_WRITE_UPDATE: begin
							in_reg[i] <= data;
							dac_reg[i] <= data;
						end
						default: ;
					endcase
				end
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dac_a_o <= ZERO_CODE;
			dac_b_o <= ZERO_CODE;
			dac_c_o <= ZERO_CODE;
			dac_d_o <= ZERO_CODE;
		end else begin
			dac_a_o <= dac_reg[0];
			dac_b_o <= dac_reg[1];
			dac_c_o <= dac_reg[2];
			dac_d_o <= dac_reg[3];
		end
	end
endmodule : qdu_core
`default_nettype wire

// ### core/qdu_pkg.sv
package qdu_pkg;
	localparam int FRAME_BITS = 24;
	localparam int CMD_HI = 23;
	localparam int CMD_LO = 20;
	localparam int ADDR_HI = 19;
	localparam int ADDR_LO = 16;
	localparam int DATA_HI = 15;
	localparam int DATA_LO = 0;
	localparam int REF_BIT = 0;
	localparam int NUM_CH = 4;
	localparam int DAC_BITS = 16;
	localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
	localparam logic [3:0] CMD_UPDATE_DAC = 4'h2;
	localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
	localparam logic [3:0] CMD_LOAD_MASK = 4'h5;
	localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
	localparam logic [3:0] CMD_REF_SETUP = 4'h7;
	localparam logic [15:0] ZERO_CODE = 16'h0000;
	localparam logic [15:0] MID_CODE = 16'h8000;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic REF_DISABLE_RESET = 1'b0;
	// Cycles of power-on initialization after reset release
	localparam int POR_CYCLES = 8;
	localparam int POR_CNT_BITS = 4;
endpackage : qdu_pkg

// ### core/qdu_sync.sv
`timescale 1ns/10ps
`default_nettype none
module qdu_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input wire logic core_clk_i, // Core clock
	input wire logic rstn_i, // Async reset, active low
	input wire logic [WIDTH-1:0] async_i, // Raw pin levels
	input wire logic [WIDTH-1:0] reset_val_i, // Unused at reset, kept constant
	output logic [WIDTH-1:0] sync_o // Synchronised levels
);
	logic [WIDTH-1:0] stage1;
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stage1 <= RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
	logic unused_ok;
	assign unused_ok = ^reset_val_i;
endmodule : qdu_sync
`default_nettype wire

// ### core/qdu_shift_rx.sv
`timescale 1ns/10ps
`default_nettype none
module qdu_shift_rx
	import qdu_pkg::*;
(
	input wire logic core_clk_i, // Core clock
	input wire logic rstn_i, // Async reset, active low
	input wire logic sclk_s_i, // Synchronised serial clock
	input wire logic sdin_s_i, // Synchronised serial data
	input wire logic sync_n_s_i, // Synchronised frame select, active low
	output logic [FRAME_BITS-1:0] word_o, // Received word
	output logic word_valid_o // One-cycle pulse, full frame done
);
	logic sclk_d;
	logic sync_n_d;
	logic [4:0] bit_cnt;
	logic [FRAME_BITS-1:0] shreg;
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sclk_d <= 1'b0;
			sync_n_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s_i;
			sync_n_d <= sync_n_s_i;
		end
	end
	// Shift MSB first on falling serial clock edges while framed
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shreg <= '0;
			bit_cnt <= '0;
		end else if (sync_n_s_i && !sync_n_d) begin
			bit_cnt <= '0;
		end else if (!sync_n_s_i && sync_n_d) begin
			bit_cnt <= '0;
		end else if (!sync_n_s_i && sclk_d && !sclk_s_i) begin
			shreg <= {shreg[FRAME_BITS-2:0], sdin_s_i};
			if (bit_cnt != 5'(FRAME_BITS))
				bit_cnt <= bit_cnt + 5'h01;
		end
	end
	// Word latched on every select rising edge, flagged valid only when at least 24 bits came in
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word_o <= '0;
			word_valid_o <= 1'b0;
		end else begin
			word_valid_o <= sync_n_s_i && !sync_n_d && (bit_cnt == 5'(FRAME_BITS));
			if (sync_n_s_i && !sync_n_d)
				word_o <= shreg;
		end
	end
endmodule : qdu_shift_rx
`default_nettype wire

// ### test/qdu_host.sv
`timescale 1ns/10ps
`default_nettype none
module qdu_host (
	output logic sclk_o, // Serial clock
	output logic sdin_o, // Serial data
	output logic sync_n_o // Frame select
);
	initial begin
		sclk_o = 1'b1;
		sdin_o = 1'b0;
		sync_n_o = 1'b1;
	end
	// MSB first, bit set 80 ns before each falling edge
	task automatic send(input logic [23:0] w);
		sync_n_o = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdin_o = w[i];
			#80 sclk_o = 1'b0;
			#80 sclk_o = 1'b1;
		end
		#80 sync_n_o = 1'b1;
		// Released line shows garbage, not the last bit
		sdin_o = ~w[0];
		#200;
	endtask : send
endmodule : qdu_host
`default_nettype wire

// ### test/qdu_core_sva.sv
`timescale 1ns/10ps
`default_nettype none
module qdu_core_sva
	import qdu_pkg::*;
(
	input wire logic core_clk_i, // Clock
	input wire logic rstn_i, // Reset
	input wire logic sclk_i, // Serial clock
	input wire logic sdin_i, // Serial data
	input wire logic sync_n_i, // Frame select
	input wire logic load_strobe_n_i, // Strobe
	input wire logic hw_reset_n_i, // Hw reset
	input wire logic reset_level_select_i, // Code select
	input wire logic [DAC_BITS-1:0] dac_a_o, // Dac a
	input wire logic [DAC_BITS-1:0] dac_b_o, // Dac b
	input wire logic [DAC_BITS-1:0] dac_c_o, // Dac c
	input wire logic [DAC_BITS-1:0] dac_d_o, // Dac d
	input wire logic ref_enable_o, // Reference on
	input wire logic [NUM_CH-1:0] load_mask_o, // Mask
	input wire logic ready_o // Ready
);
	logic [3:0] quiet;
	wire logic [63:0] dacs = {dac_a_o, dac_b_o, dac_c_o, dac_d_o};
	wire logic [15:0] code = reset_level_select_i ? MID_CODE : ZERO_CODE;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	// Cycles since last frame, strobe fall or hw reset
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			quiet <= 4'h0;
		else if (!sync_n_i || !hw_reset_n_i || $fell(load_strobe_n_i))
			quiet <= 4'h0;
		else if (quiet != 4'hf)
			quiet <= quiet + 4'h1;
	end
	chk_hw_code: assert property (!hw_reset_n_i [*8] |-> dacs == {4{code}})
		else $error("dac not at clear code");
	chk_hw_frozen: assert property (!hw_reset_n_i [*8] ##1 !hw_reset_n_i |-> $stable(dacs))
		else $error("dac moved in hw reset");
	chk_ready_held: assert property (!hw_reset_n_i && !ready_o |=> !ready_o)
		else $error("ready rose in hw reset");
	chk_ref_at_ready: assert property ($rose(ready_o) |-> ref_enable_o)
		else $error("reference off at start");
	chk_dac_quiet: assert property ($changed(dacs) |-> quiet < 4'h8)
		else $error("dac moved with no cause");
	chk_mask_quiet: assert property ($changed(load_mask_o) |-> quiet < 4'h8)
		else $error("mask moved with no frame");
	chk_ref_quiet: assert property ($changed(ref_enable_o) |-> quiet < 4'h8)
		else $error("reference moved with no frame");
	chk_masked_strobe: assert property ($fell(load_strobe_n_i) && load_mask_o == 4'hf
		&& ready_o && quiet > 4'h8 |=> $stable(dacs) [*6])
		else $error("masked dac followed strobe");
	cover property ($fell(load_strobe_n_i) && ready_o);
	cover property (!hw_reset_n_i [*8]);
	cover property ($fell(ref_enable_o));
endmodule : qdu_core_sva
bind qdu_core qdu_core_sva chk (.core_clk_i, .rstn_i, .sclk_i, .sdin_i, .sync_n_i,
	.load_strobe_n_i, .hw_reset_n_i, .reset_level_select_i, .dac_a_o, .dac_b_o,
	.dac_c_o, .dac_d_o, .ref_enable_o, .load_mask_o, .ready_o);
`default_nettype wire

// ### test/qdu_core_bench.sv
`timescale 1ns/10ps
`default_nettype none
module qdu_core_bench
	import qdu_pkg::*;
;
	logic clk = 1'b0, rstn = 1'b0, lsn = 1'b1, hwn = 1'b1, sel = 1'b0;
	wire logic sclk, sdin, syncn, ref_en, rdy;
	wire logic [15:0] da, db, dc, dd;
	wire logic [3:0] mask;
	int fails = 0, n_compared = 0, cyc = 0;
	qdu_host host (.sclk_o(sclk), .sdin_o(sdin), .sync_n_o(syncn));
	qdu_core dut (.core_clk_i(clk), .rstn_i(rstn), .sclk_i(sclk), .sdin_i(sdin),
		.sync_n_i(syncn), .load_strobe_n_i(lsn), .hw_reset_n_i(hwn),
		.reset_level_select_i(sel), .dac_a_o(da), .dac_b_o(db), .dac_c_o(dc),
		.dac_d_o(dd), .ref_enable_o(ref_en), .load_mask_o(mask), .ready_o(rdy));
	initial forever #10 clk = ~clk;
	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end
	task automatic check(input string what, input logic [15:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	task automatic tx(input logic [3:0] cmd, addr, input logic [15:0] d);
		host.send({cmd, addr, d});
		repeat (8) @(negedge clk);
	endtask : tx
	task automatic strobe();
		lsn = 1'b0;
		repeat (4) @(negedge clk);
		lsn = 1'b1;
		repeat (6) @(negedge clk);
	endtask : strobe
	task automatic do_reset(input logic hw);
		rstn = 1'b0;
		hwn = hw;
		repeat (6) @(negedge clk);
		rstn = 1'b1;
	endtask : do_reset
	task automatic wait_ready();
		for (int i = 0; i < 40 && rdy !== 1'b1; i++)
			@(negedge clk);
		check("ready", {15'h0, rdy}, 16'h1);
	endtask : wait_ready
	task automatic t_power();
		check("dac a", da, ZERO_CODE);
		check("dac d", dd, ZERO_CODE);
		check("ref", {15'h0, ref_en}, 16'h1);
		check("mask", {12'h0, mask}, {12'h0, MASK_RESET});
		$display("power-up done");
	endtask : t_power
	task automatic t_write();
		tx(CMD_WRITE_INPUT, 4'h1, 16'h1234);
		check("dac a", da, ZERO_CODE);
		strobe();
		check("dac a", da, 16'h1234);
		tx(CMD_WRITE_INPUT, 4'h2, 16'h5555);
		tx(CMD_UPDATE_DAC, 4'h2, 16'h0);
		check("dac b", db, 16'h5555);
		tx(CMD_WRITE_UPDATE, 4'hc, 16'h0abc);
		check("dac c", dc, 16'h0abc);
		check("dac d", dd, 16'h0abc);
		$display("writes done");
	endtask : t_write
	task automatic t_mask();
		tx(CMD_LOAD_MASK, 4'h0, 16'h0005);
		check("mask", {12'h0, mask}, 16'h0005);
		tx(CMD_WRITE_INPUT, 4'hf, 16'h7777);
		strobe();
		check("dac a", da, 16'h1234);
		check("dac b", db, 16'h7777);
		check("dac c", dc, 16'h0abc);
		tx(CMD_LOAD_MASK, 4'h0, 16'h000f);
		tx(CMD_WRITE_INPUT, 4'h8, 16'h9999);
		repeat (4) @(negedge clk);
		strobe();
		check("dac d", dd, 16'h7777);
		lsn = 1'b0;
		tx(CMD_WRITE_INPUT, 4'h1, 16'h2222);
		check("dac a", da, 16'h2222);
		lsn = 1'b1;
		$display("mask done");
	endtask : t_mask
	task automatic t_ref();
		tx(CMD_REF_SETUP, 4'ha, 16'h5a5b);
		check("ref", {15'h0, ref_en}, 16'h0);
		tx(CMD_REF_SETUP, 4'h5, 16'ha5a4);
		check("ref", {15'h0, ref_en}, 16'h1);
		tx(CMD_SOFT_RESET, 4'h0, 16'h0);
		check("dac b", db, ZERO_CODE);
		check("mask", {12'h0, mask}, 16'h0);
		$display("reference and soft reset done");
	endtask : t_ref
	task automatic t_hw();
		tx(CMD_WRITE_UPDATE, 4'hf, 16'h3333);
		sel = 1'b1;
		hwn = 1'b0;
		repeat (10) @(negedge clk);
		check("dac a", da, MID_CODE);
		tx(CMD_WRITE_UPDATE, 4'h1, 16'h4444);
		strobe();
		check("dac a", da, MID_CODE);
		hwn = 1'b1;
		repeat (20) @(negedge clk);
		check("dac c", dc, MID_CODE);
		do_reset(1'b0);
		repeat (30) @(negedge clk);
		check("ready", {15'h0, rdy}, 16'h0);
		strobe();
		hwn = 1'b1;
		wait_ready();
		check("dac b", db, MID_CODE);
		$display("hardware reset done");
	endtask : t_hw
	initial begin
		do_reset(1'b1);
		wait_ready();
		t_power();
		t_write();
		t_mask();
		t_ref();
		t_hw();
		conclude();
	end
endmodule : qdu_core_bench
`default_nettype wire
